// file: src/rcc_ctrl.sv
/*
 * Retry timeout, card control and multifunction pin routing registers
 * behind an AXI4-Lite slave.
 * Map: retry 0x240, card control 0x244, routing 0x300, interrupt
 * status 0x304, clear 0x308 and enable 0x30c; writes use byte 0 only.
 * Assumes all inputs are synchronous to ref_clk and event inputs are
 * one-cycle pulses.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "rcc_regs.svh"

// Operation
// - Bits 7-4 pick the source of multifunction terminal one.
// - Serial bus mode via both supply pull-ups makes terminal one the data line.
// - Bits 3-0 pick terminal zero source; upper codes shared by both terminals.
// - Unreturned retried master sets its expiry flag after the cycle limit.
// - Retry bit 7 enables the host counter, reset one.
// - Retry bit 6 enables the card counter, reset one.
// - Retry bit 3 is the card expiry flag, write one clears.
// - Retry bit 1 is the host expiry flag, write one clears.
// - Retry bits 5, 4, 2, 0 read zero and ignore writes.
// - Card bit 7 gates ring indicate onto its pins, power pin needs mux zero.
// - Card bit 6 places the video terminals in high impedance.
// - Card bit 5 is plain storage with no effect.
// - Card bits 4 and 3 read zero.
// - Card bit 2 routes card audio to the audio PWM terminal.
// - Card bit 1 routes the speaker signal and enables the speaker pin drive.
// - Card bit 0 sets on a card functional interrupt, write one clears.
module rcc_ctrl #(
   parameter int RETRY_CYCLES = `RCC_RETRY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic host_retry_issued,
   input wire logic host_master_returned,
   input wire logic card_retry_issued,
   input wire logic card_master_returned,
   input wire logic card_function_irq,
   input wire logic supply_ctrl_a,
   input wire logic supply_ctrl_b,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   input wire logic [15:0] irq_lines,
   input wire logic inta_line,
   input wire logic video_status,
   input wire logic video_select,
   input wire logic socket_activity_led,
   input wire logic general_purpose_event,
   input wire logic card_audio_input,
   input wire logic card_speaker_signal,
   input wire logic ring_indicate,
   input wire logic ring_pin_mux_select,
   input wire logic multi_pin_zero_in,
   input wire logic multi_pin_one_in,
   output rcc_pkg::rcc_pin_t multi_pin_zero_select,
   output rcc_pkg::rcc_pin_t multi_pin_one_select,
   output rcc_pkg::rcc_pin_t speaker_output_pin,
   output logic serial_data_in,
   output logic video_tristate_enable,
   output logic ring_pme_pin,
   output logic ring_indicate_output,
   output logic irq
);
   import rcc_pkg::*;

   // Last count value before a retried master is declared lost.
   localparam logic [15:0] LIMIT = 16'(RETRY_CYCLES - 1);

   // The whole state of the bank is one registered word.
   rcc_state_t state_ff;
   rcc_state_t nxt_state;

   // Maps a routing code onto the drive of one terminal.
   function automatic rcc_pin_t route_pin(input logic [3:0] sel, input logic gpo,
                                          input logic audio_en);
      rcc_pin_t p;
      p.oe = 1'b1;
      p.out = 1'b0;
      case (rcc_sel_t'(sel))
         RCC_SEL_GPI: p.oe = 1'b0;
         RCC_SEL_GPO: p.out = gpo;
         RCC_SEL_INTA: p.out = inta_line;
         RCC_SEL_IRQ3: p.out = irq_lines[3];
         RCC_SEL_IRQ4: p.out = irq_lines[4];
         RCC_SEL_IRQ5: p.out = irq_lines[5];
         RCC_SEL_VSTAT: p.out = video_status;
         RCC_SEL_VSEL: p.out = video_select;
         RCC_SEL_AUDIO: p.out = audio_en & card_audio_input;
         RCC_SEL_IRQ9: p.out = irq_lines[9];
         RCC_SEL_IRQ10: p.out = irq_lines[10];
         RCC_SEL_IRQ11: p.out = irq_lines[11];
         RCC_SEL_LED: p.out = socket_activity_led;
         RCC_SEL_IRQ13: p.out = irq_lines[13];
         RCC_SEL_EVENT: p.out = general_purpose_event;
         default: p.out = irq_lines[15];
      endcase
      return p;
   endfunction

   logic [1:0] retry_issued;
   logic [1:0] master_back;
   logic [1:0] count_en;
   logic [1:0] expired;
   logic wr_do;
   logic wr_clr;
   logic serial_mode;
   logic aw_take;
   logic w_take;
   logic wr_land;
   logic b_done;
   logic ar_take;
   logic r_done;
   logic [7:0] wr_byte;
   logic [11:0] wr_addr;

   // Per-channel views: bit 0 is the host bus, bit 1 the card bus.
   assign retry_issued = {card_retry_issued, host_retry_issued};
   assign master_back = {card_master_returned, host_master_returned};
   assign count_en = {state_ff.retry[`RCC_BIT_CARD_EN], state_ff.retry[`RCC_BIT_HOST_EN]};
   assign serial_mode = supply_ctrl_a & supply_ctrl_b;
   assign aw_take = s_axi_awvalid & state_ff.axi.awready;
   assign w_take = s_axi_wvalid & state_ff.axi.wready;
   assign wr_land = state_ff.axi.have_aw & state_ff.axi.have_w & ~state_ff.axi.bvalid;
   assign b_done = state_ff.axi.bvalid & s_axi_bready;
   assign ar_take = s_axi_arvalid & state_ff.axi.arready;
   assign r_done = state_ff.axi.rvalid & s_axi_rready;
   assign wr_byte = state_ff.axi.wdata;
   assign wr_addr = state_ff.axi.awaddr;

   always_comb begin
      nxt_state = state_ff;
      wr_do = 1'b0;
      wr_clr = 1'b0;
      expired = 2'b00;

      // A counter runs from a retry until its master returns or time runs out.
      for (int i = 0; i < 2; i++) begin
         if (!count_en[i] || master_back[i]) begin
            nxt_state.active[i] = 1'b0;
            nxt_state.count[i] = 16'h0000;
         end else if (retry_issued[i] && !state_ff.active[i]) begin
            nxt_state.active[i] = 1'b1;
            nxt_state.count[i] = 16'h0000;
         end else if (state_ff.active[i]) begin
            if (state_ff.count[i] == LIMIT) begin
               expired[i] = 1'b1;
               nxt_state.active[i] = 1'b0;
            end else begin
               nxt_state.count[i] = state_ff.count[i] + 16'h0001;
            end
         end
      end

      // Address and data are taken in either order and held until the write lands.
      if (aw_take) begin
         nxt_state.axi.have_aw = 1'b1;
         nxt_state.axi.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         nxt_state.axi.have_w = 1'b1;
         nxt_state.axi.wdata = s_axi_wdata[7:0];
         nxt_state.axi.wstrb0 = s_axi_wstrb[0];
      end

      // The response stands until bready is seen high.
      if (b_done) begin
         nxt_state.axi.bvalid = 1'b0;
      end

      // The write lands once both halves are held and no response is pending.
      if (wr_land) begin
         wr_do = state_ff.axi.wstrb0;
         nxt_state.axi.have_aw = 1'b0;
         nxt_state.axi.have_w = 1'b0;
         nxt_state.axi.bvalid = 1'b1;
         nxt_state.axi.bresp = `RCC_RESP_OKAY;
         if (wr_addr == `RCC_ADDR_RETRY) begin
            if (wr_do) begin
               nxt_state.retry[`RCC_BIT_HOST_EN] = wr_byte[`RCC_BIT_HOST_EN];
               nxt_state.retry[`RCC_BIT_CARD_EN] = wr_byte[`RCC_BIT_CARD_EN];
               if (wr_byte[`RCC_BIT_CARD_EXP]) begin
                  nxt_state.retry[`RCC_BIT_CARD_EXP] = 1'b0;
               end
               if (wr_byte[`RCC_BIT_HOST_EXP]) begin
                  nxt_state.retry[`RCC_BIT_HOST_EXP] = 1'b0;
               end
            end
         end else if (wr_addr == `RCC_ADDR_CARD) begin
            if (wr_do) begin
               nxt_state.card[7:5] = wr_byte[7:5];
               nxt_state.card[2:1] = wr_byte[2:1];
               if (wr_byte[`RCC_BIT_FUNC_IRQ]) begin
                  nxt_state.card[`RCC_BIT_FUNC_IRQ] = 1'b0;
               end
            end
         end else if (wr_addr == `RCC_ADDR_ROUTE) begin
            if (wr_do) begin
               nxt_state.route = wr_byte;
            end
         end else if (wr_addr == `RCC_ADDR_IRQ_CLR) begin
            wr_clr = wr_do;
         end else if (wr_addr == `RCC_ADDR_IRQ_EN) begin
            if (wr_do) begin
               nxt_state.irq_en = wr_byte[2:0];
            end
         end else begin
            nxt_state.axi.bresp = `RCC_RESP_SLVERR;
         end
      end

      // General outputs are not writable and hold their value.
      if (wr_land && wr_addr == `RCC_ADDR_ROUTE) begin
         nxt_state.gpo = state_ff.gpo;
      end

      // Reserved bits always read zero.
      nxt_state.retry[5:4] = 2'b00;
      nxt_state.retry[2] = 1'b0;
      nxt_state.retry[0] = 1'b0;
      nxt_state.card[4:3] = 2'b00;

      // Hardware set wins over a clear written in the same cycle.
      if (expired[1]) begin
         nxt_state.retry[`RCC_BIT_CARD_EXP] = 1'b1;
      end
      if (expired[0]) begin
         nxt_state.retry[`RCC_BIT_HOST_EXP] = 1'b1;
      end
      if (card_function_irq) begin
         nxt_state.card[`RCC_BIT_FUNC_IRQ] = 1'b1;
      end

      // Interrupt status follows the same order: clear first, then set.
      if (wr_clr) begin
         nxt_state.irq_stat = state_ff.irq_stat & ~wr_byte[2:0];
      end
      nxt_state.irq_stat = nxt_state.irq_stat | {card_function_irq, expired[1], expired[0]};
      nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_en);

      // A read is answered at the edge after its address is taken.
      if (r_done) begin
         nxt_state.axi.rvalid = 1'b0;
      end
      if (ar_take) begin
         nxt_state.axi.rvalid = 1'b1;
         nxt_state.axi.rresp = `RCC_RESP_OKAY;
         nxt_state.axi.rdata = 32'h0000_0000;
         if (s_axi_araddr == `RCC_ADDR_RETRY) begin
            nxt_state.axi.rdata[7:0] = state_ff.retry;
         end else if (s_axi_araddr == `RCC_ADDR_CARD) begin
            nxt_state.axi.rdata[7:0] = state_ff.card;
         end else if (s_axi_araddr == `RCC_ADDR_ROUTE) begin
            nxt_state.axi.rdata[7:0] = state_ff.route;
            nxt_state.axi.rdata[`RCC_BIT_GENERAL_OUTPUT_ZERO] = state_ff.gpo[0];
            nxt_state.axi.rdata[`RCC_BIT_GENERAL_OUTPUT_ONE] = state_ff.gpo[1];
            nxt_state.axi.rdata[`RCC_BIT_GENERAL_INPUT_ZERO] = multi_pin_zero_in;
            nxt_state.axi.rdata[`RCC_BIT_GENERAL_INPUT_ONE] = multi_pin_one_in;
         end else if (s_axi_araddr == `RCC_ADDR_IRQ_STAT) begin
            nxt_state.axi.rdata[2:0] = state_ff.irq_stat;
         end else if (s_axi_araddr == `RCC_ADDR_IRQ_CLR) begin
            nxt_state.axi.rdata = 32'h0000_0000;
         end else if (s_axi_araddr == `RCC_ADDR_IRQ_EN) begin
            nxt_state.axi.rdata[2:0] = state_ff.irq_en;
         end else begin
            nxt_state.axi.rresp = `RCC_RESP_SLVERR;
         end
      end

      // Readies fall while a request is held or its answer stands.
      nxt_state.axi.awready = !nxt_state.axi.have_aw && !nxt_state.axi.bvalid;
      nxt_state.axi.wready = !nxt_state.axi.have_w && !nxt_state.axi.bvalid;
      nxt_state.axi.arready = !nxt_state.axi.rvalid;

      // Pin images are registered from the next state.
      nxt_state.pin_zero = route_pin(nxt_state.route[3:0], nxt_state.gpo[0],
                                     nxt_state.card[`RCC_BIT_AUDIO]);
      nxt_state.pin_one = route_pin(nxt_state.route[7:4], nxt_state.gpo[1],
                                    nxt_state.card[`RCC_BIT_AUDIO]);
      if (nxt_state.route[7:4] == 4'h2) begin
         nxt_state.pin_one.oe = 1'b0;
      end
      if (serial_mode) begin
         nxt_state.pin_one.out = serial_data_out;
         nxt_state.pin_one.oe = serial_data_oe;
      end
      nxt_state.serial_data_in = serial_mode & multi_pin_one_in;

      // Card control outputs.
      nxt_state.speaker.oe = nxt_state.card[`RCC_BIT_SPEAKER];
      nxt_state.speaker.out = nxt_state.card[`RCC_BIT_SPEAKER] & card_speaker_signal;
      nxt_state.video_tristate = nxt_state.card[`RCC_BIT_VIDEO_TRI];
      nxt_state.ring_route = nxt_state.card[`RCC_BIT_RING_EN] & ring_indicate;
      nxt_state.ring_pme = nxt_state.ring_route & !ring_pin_mux_select;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= '0;
         state_ff.retry <= `RCC_RETRY_RESET;
         state_ff.card <= `RCC_CARD_RESET;
         state_ff.route <= `RCC_ROUTE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Every output is a flip-flop of the state word.
   assign s_axi_awready = state_ff.axi.awready;
   assign s_axi_wready = state_ff.axi.wready;
   assign s_axi_bvalid = state_ff.axi.bvalid;
   assign s_axi_bresp = state_ff.axi.bresp;
   assign s_axi_arready = state_ff.axi.arready;
   assign s_axi_rvalid = state_ff.axi.rvalid;
   assign s_axi_rresp = state_ff.axi.rresp;
   assign s_axi_rdata = state_ff.axi.rdata;
   assign multi_pin_zero_select = state_ff.pin_zero;
   assign multi_pin_one_select = state_ff.pin_one;
   assign speaker_output_pin = state_ff.speaker;
   assign serial_data_in = state_ff.serial_data_in;
   assign video_tristate_enable = state_ff.video_tristate;
   assign ring_pme_pin = state_ff.ring_pme;
   assign ring_indicate_output = state_ff.ring_route;
   assign irq = state_ff.irq;
endmodule // rcc_ctrl

// file: src/rcc_regs.svh
/*
 * Register indices, byte addresses, field positions, reset values and
 * timing counts of the retry and card control register bank.
 * Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
 */
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH
`define RCC_IDX_RETRY 8'h90
`define RCC_IDX_CARD 8'h91
`define RCC_ADDR_RETRY 12'h240
`define RCC_ADDR_CARD 12'h244
`define RCC_ADDR_ROUTE 12'h300
`define RCC_ADDR_IRQ_STAT 12'h304
`define RCC_ADDR_IRQ_CLR 12'h308
`define RCC_ADDR_IRQ_EN 12'h30c
`define RCC_RETRY_RESET 8'hc0
`define RCC_CARD_RESET 8'h00
`define RCC_ROUTE_RESET 8'h00
`define RCC_BIT_HOST_EN 7
`define RCC_BIT_CARD_EN 6
`define RCC_BIT_CARD_EXP 3
`define RCC_BIT_HOST_EXP 1
`define RCC_BIT_RING_EN 7
`define RCC_BIT_VIDEO_TRI 6
`define RCC_BIT_SPARE 5
`define RCC_BIT_AUDIO 2
`define RCC_BIT_SPEAKER 1
`define RCC_BIT_FUNC_IRQ 0
`define RCC_BIT_GENERAL_OUTPUT_ZERO 8
`define RCC_BIT_GENERAL_OUTPUT_ONE 9
`define RCC_BIT_GENERAL_INPUT_ZERO 10
`define RCC_BIT_GENERAL_INPUT_ONE 11
`define RCC_RETRY_CYCLES 32768
`define RCC_RESP_OKAY 2'h0
`define RCC_RESP_SLVERR 2'h2
`endif

// file: src/rcc_pkg.sv
/*
 * Types of the retry and card control register bank.
 * Assumes the constants of rcc_regs.svh.
 */
package rcc_pkg;
   typedef struct packed {
      logic out;
      logic oe;
   } rcc_pin_t;

   typedef enum logic [3:0] {
      RCC_SEL_GPI, RCC_SEL_GPO, RCC_SEL_INTA, RCC_SEL_IRQ3,
      RCC_SEL_IRQ4, RCC_SEL_IRQ5, RCC_SEL_VSTAT, RCC_SEL_VSEL,
      RCC_SEL_AUDIO, RCC_SEL_IRQ9, RCC_SEL_IRQ10, RCC_SEL_IRQ11,
      RCC_SEL_LED, RCC_SEL_IRQ13, RCC_SEL_EVENT, RCC_SEL_IRQ15
   } rcc_sel_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic have_aw;
      logic have_w;
      logic [11:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
   } rcc_axi_t;

   typedef struct packed {
      rcc_axi_t axi;
      logic [7:0] retry;
      logic [7:0] card;
      logic [7:0] route;
      logic [1:0] gpo;
      logic [2:0] irq_stat;
      logic [2:0] irq_en;
      logic irq;
      logic [1:0] active;
      logic [1:0][15:0] count;
      rcc_pin_t pin_zero;
      rcc_pin_t pin_one;
      rcc_pin_t speaker;
      logic video_tristate;
      logic ring_pme;
      logic ring_route;
      logic serial_data_in;
   } rcc_state_t;
endpackage

// file: verif/rcc_ctrl_properties.sv
/* Checker of the retry and card control bank, watching only its ports.
   Assumes the single ref_clk domain and the active-low reset_n. */
`timescale 1ns/1ps
`include "rcc_regs.svh"
module rcc_ctrl_checker #(
   parameter int RETRY_CYCLES = `RCC_RETRY_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bready,
   input wire logic supply_ctrl_a,
   input wire logic supply_ctrl_b,
   input wire logic serial_data_oe,
   input wire logic multi_pin_one_in,
   input wire logic card_speaker_signal,
   input wire logic ring_indicate,
   input wire logic ring_pin_mux_select,
   input wire rcc_pkg::rcc_pin_t multi_pin_one_select,
   input wire rcc_pkg::rcc_pin_t speaker_output_pin,
   input wire logic serial_data_in,
   input wire logic ring_pme_pin,
   input wire logic ring_indicate_output
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence rd_retry;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `RCC_ADDR_RETRY;
   endsequence
   sequence rd_card;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `RCC_ADDR_CARD;
   endsequence
   retry_reserved_a: assert property (rd_retry |=> s_axi_rdata[31:8] == 24'h0 &&
      s_axi_rdata[5:4] == 2'h0 && !s_axi_rdata[2] && !s_axi_rdata[0]) else $error("reserved set");
   card_reserved_a: assert property (rd_card |=> s_axi_rdata[4:3] == 2'h0)
      else $error("card reserved bits set");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
   serial_pin_a: assert property (supply_ctrl_a && supply_ctrl_b |=>
      multi_pin_one_select.oe == $past(serial_data_oe) && serial_data_in == $past(multi_pin_one_in))
      else $error("serial line not routed");
   serial_off_a: assert property (!(supply_ctrl_a && supply_ctrl_b) |=> !serial_data_in)
      else $error("serial input outside serial mode");
   ring_pin_a: assert property (ring_pme_pin |-> ring_indicate_output
      && !$past(ring_pin_mux_select)) else $error("ring pin wrongly driven");
   ring_source_a: assert property (ring_indicate_output |-> $past(ring_indicate))
      else $error("ring output without ring");
   speaker_follow_a: assert property (speaker_output_pin.oe |->
      speaker_output_pin.out == $past(card_speaker_signal)) else $error("speaker data wrong");
endmodule // rcc_ctrl_checker
bind rcc_ctrl rcc_ctrl_checker #(.RETRY_CYCLES(RETRY_CYCLES)) i_check (.ref_clk, .reset_n,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .supply_ctrl_a, .supply_ctrl_b, .serial_data_oe,
   .multi_pin_one_in, .card_speaker_signal, .ring_indicate, .ring_pin_mux_select,
   .multi_pin_one_select, .speaker_output_pin, .serial_data_in, .ring_pme_pin,
   .ring_indicate_output);

// file: verif/rcc_far_end.sv
/* Model of the far side: retried host and card masters and the card interrupt.
   Assumes one clock and a bench that calls its tasks. */
`timescale 1ns/1ps
module rcc_far_end (
   input wire logic ref_clk,
   output logic host_retry_issued,
   output logic host_master_returned,
   output logic card_retry_issued,
   output logic card_master_returned,
   output logic card_function_irq
);
   logic [1:0] iss = 2'h0;
   logic [1:0] ret = 2'h0;
   logic func = 1'h0;
   assign host_retry_issued = iss[0];
   assign card_retry_issued = iss[1];
   assign host_master_returned = ret[0];
   assign card_master_returned = ret[1];
   assign card_function_irq = func;
   // Retries one master; a gap of zero means it never comes back.
   task automatic retry(input int ch, input int gap);
      @(posedge ref_clk);
      iss[ch] <= 1'h1;
      @(posedge ref_clk);
      iss[ch] <= 1'h0;
      if (gap > 0) begin
         repeat (gap) @(posedge ref_clk);
         ret[ch] <= 1'h1;
         @(posedge ref_clk);
         ret[ch] <= 1'h0;
      end
   endtask
   task automatic card_irq();
      @(posedge ref_clk);
      func <= 1'h1;
      @(posedge ref_clk);
      func <= 1'h0;
   endtask
endmodule // rcc_far_end

// file: verif/rcc_ctrl_bench.sv
/* Self-checking bench of the retry and card control bank.
   Assumes the far side model and the bound checker. */
`timescale 1ns/1ps
`include "rcc_regs.svh"
module rcc_ctrl_bench;
   import rcc_pkg::*;
   localparam int RC = 16;
   logic ref_clk = 1'h0, reset_n = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic host_retry_issued, host_master_returned, card_retry_issued, card_master_returned;
   logic card_function_irq, serial_data_in, video_tristate_enable, ring_pme_pin;
   logic ring_indicate_output, irq;
   logic supply_ctrl_a = 1'h0, supply_ctrl_b = 1'h0, serial_data_out = 1'h0;
   logic serial_data_oe = 1'h0, inta_line = 1'h0, video_status = 1'h0, video_select = 1'h0;
   logic socket_activity_led = 1'h0, general_purpose_event = 1'h0, card_audio_input = 1'h0;
   logic card_speaker_signal = 1'h0, ring_indicate = 1'h0, ring_pin_mux_select = 1'h0;
   logic multi_pin_zero_in = 1'h0, multi_pin_one_in = 1'h0;
   logic [15:0] irq_lines = 16'h0;
   rcc_pin_t multi_pin_zero_select, multi_pin_one_select, speaker_output_pin;
   int n_mismatch = 0, checks_done = 0, cycles = 0;
   rcc_ctrl #(.RETRY_CYCLES(RC)) i_dut (.*);
   rcc_far_end i_far (.*);
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic pa;
      logic pw;
      pa = 1'h1;
      pw = 1'h1;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (pa || pw) begin
         @(negedge ref_clk);
         pa = pa && s_axi_awready !== 1'h1;
         pw = pw && s_axi_wready !== 1'h1;
         @(posedge ref_clk);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      do @(negedge ref_clk); while (s_axi_bvalid !== 1'h1);
      wr_resp = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(negedge ref_clk); while (s_axi_arready !== 1'h1);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'h0;
      do @(negedge ref_clk); while (s_axi_rvalid !== 1'h1);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'h0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      check(rd_data, exp);
      check(rd_resp, `RCC_RESP_OKAY);
   endtask
   task automatic t_reset();
      rdc(`RCC_ADDR_RETRY, 32'hc0);
      rdc(`RCC_ADDR_CARD, 32'h0);
      rdc(`RCC_ADDR_ROUTE, 32'h0);
      rd(12'h100);
      check(rd_data, 32'h0);
      check(rd_resp, `RCC_RESP_SLVERR);
      wr(12'h104, 8'hff);
      check(wr_resp, `RCC_RESP_SLVERR);
   endtask
   task automatic t_retry_bits();
      wr(`RCC_ADDR_RETRY, 8'hff);
      rdc(`RCC_ADDR_RETRY, 32'hc0);
      wr(`RCC_ADDR_RETRY, 8'h00);
      rdc(`RCC_ADDR_RETRY, 32'h0);
      i_far.retry(0, 0);
      i_far.retry(1, 0);
      repeat (RC + 4) @(posedge ref_clk);
      rdc(`RCC_ADDR_RETRY, 32'h0);
      wr(`RCC_ADDR_RETRY, 8'hc0);
   endtask
   task automatic t_expiry();
      wr(`RCC_ADDR_IRQ_EN, 8'h01);
      i_far.retry(0, 0);
      repeat (RC / 2) @(posedge ref_clk);
      rdc(`RCC_ADDR_RETRY, 32'hc0);
      repeat (RC) @(posedge ref_clk);
      rdc(`RCC_ADDR_RETRY, 32'hc2);
      i_far.retry(1, 4);
      repeat (RC + 4) @(posedge ref_clk);
      rdc(`RCC_ADDR_RETRY, 32'hc2);
      i_far.retry(1, 0);
      repeat (RC + 4) @(posedge ref_clk);
      rdc(`RCC_ADDR_RETRY, 32'hca);
      rdc(`RCC_ADDR_IRQ_STAT, 32'h3);
      settle();
      check(irq, 1'h1);
      wr(`RCC_ADDR_IRQ_EN, 8'h00);
      settle();
      check(irq, 1'h0);
      wr(`RCC_ADDR_IRQ_EN, 8'h01);
      wr(`RCC_ADDR_RETRY, 8'hc0);
      rdc(`RCC_ADDR_RETRY, 32'hca);
      settle();
      check(irq, 1'h1);
      wr(`RCC_ADDR_IRQ_CLR, 8'h01);
      rdc(`RCC_ADDR_IRQ_STAT, 32'h2);
      check(irq, 1'h0);
      wr(`RCC_ADDR_RETRY, 8'hca);
      rdc(`RCC_ADDR_RETRY, 32'hc0);
   endtask
   task automatic t_card();
      wr(`RCC_ADDR_CARD, 8'hff);
      rdc(`RCC_ADDR_CARD, 32'he6);
      @(posedge ref_clk);
      ring_indicate <= 1'h1;
      card_speaker_signal <= 1'h1;
      settle();
      check({video_tristate_enable, ring_pme_pin, ring_indicate_output}, 3'h7);
      check(speaker_output_pin, 2'h3);
      @(posedge ref_clk);
      ring_pin_mux_select <= 1'h1;
      settle();
      check({ring_pme_pin, ring_indicate_output}, 2'h1);
      i_far.card_irq();
      rdc(`RCC_ADDR_CARD, 32'he7);
      wr(`RCC_ADDR_CARD, 8'he6);
      rdc(`RCC_ADDR_CARD, 32'he7);
      wr(`RCC_ADDR_CARD, 8'he7);
      rdc(`RCC_ADDR_CARD, 32'he6);
      wr(`RCC_ADDR_CARD, 8'h04);
      settle();
      check({video_tristate_enable, ring_indicate_output, speaker_output_pin.oe}, 3'h0);
   endtask
   task automatic set_src(input logic [3:0] c, input logic v);
      @(posedge ref_clk);
      case (c)
         4'h6: video_status <= v;
         4'h7: video_select <= v;
         4'h8: card_audio_input <= v;
         4'hc: socket_activity_led <= v;
         4'he: general_purpose_event <= v;
         default: irq_lines[c] <= v;
      endcase
   endtask
   task automatic t_route();
      for (int c = 3; c < 16; c++) begin
         wr(`RCC_ADDR_ROUTE, {c[3:0], c[3:0]});
         set_src(c[3:0], 1'h1);
         settle();
         check({multi_pin_one_select, multi_pin_zero_select}, 4'hf);
         set_src(c[3:0], 1'h0);
         settle();
         check({multi_pin_one_select, multi_pin_zero_select}, 4'h5);
      end
      wr(`RCC_ADDR_ROUTE, 8'h11);
      settle();
      check({multi_pin_one_select, multi_pin_zero_select}, 4'h5);
      @(posedge ref_clk);
      inta_line <= 1'h1;
      wr(`RCC_ADDR_ROUTE, 8'h22);
      settle();
      check({multi_pin_zero_select, multi_pin_one_select.oe}, 3'h6);
      @(posedge ref_clk);
      multi_pin_zero_in <= 1'h1;
      wr(`RCC_ADDR_ROUTE, 8'h00);
      settle();
      check({multi_pin_zero_select.oe, multi_pin_one_select.oe}, 2'h0);
      rdc(`RCC_ADDR_ROUTE, 32'h400);
      @(posedge ref_clk);
      supply_ctrl_a <= 1'h1;
      supply_ctrl_b <= 1'h1;
      serial_data_oe <= 1'h1;
      serial_data_out <= 1'h1;
      multi_pin_one_in <= 1'h1;
      settle();
      check({multi_pin_one_select, serial_data_in}, 3'h7);
      rdc(`RCC_ADDR_ROUTE, 32'hc00);
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'h1;
      t_reset();
      t_retry_bits();
      t_expiry();
      t_card();
      t_route();
      stop_test();
   end
endmodule // rcc_ctrl_bench
